// ---- rtl/pcib_bridge.sv ----
// Summary of operation
// - PCI target; non-preemptable initiator for DMA
// - Positive decode; optional subtractive claim
// - Generate and check address/data parity
// - Decode configuration cycles via IDSEL
// - Forward unclaimed memory and I/O to ISA
// - Subtractive ignore: I/O, memory, or all
// - Reset into multiplexed ISA mode
// - Latch strobe only while address valid
// - Upper address 23:20 on pins 7:4
// - External-master mode supports ISA masters
// - Panel outputs off in external-master mode
// - Only ISA master memory cycles reach PCI
// - Positive decode of legacy AT I/O
// - NMI on system and parity errors
// - Seven DMA channels, two cascaded controllers
// - High page extends DMA address to 32
// - IOCHRDY low stretches the ISA cycle
// - Cascade channel grants bus to master
`timescale 1ns/10ps
`default_nettype none
module pcib_bridge #(
	parameter int SUB_CYC = pcib_pkg::SUB_WAIT_CYC,
	parameter logic [31:0] CFG_ID = 32'h1a2b_3c4d  // Arbitrary identity value
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire pcib_pkg::pcib_pci_in_s pci_i,
	output var pcib_pkg::pcib_pci_out_s pci_o,
	output var pcib_pkg::pcib_pci_oe_s pci_oe,
	input wire pcib_pkg::pcib_dec_s dec,
	input wire logic sub_ign_io,
	input wire logic sub_ign_mem,
	input wire logic ext_master_sel,
	input wire pcib_pkg::pcib_isa_in_s isa_i,
	output var pcib_pkg::pcib_isa_out_s isa_o,
	input wire logic [7:0] dma_dreq,
	input wire logic [7:0] dma_cascade,
	input wire logic dma_to_mem,
	input wire logic [23:0] dma_addr,
	input wire logic [7:0] dma_page_hi,
	output logic [7:0] dma_dack_b,
	input wire logic nmi_en,
	input wire logic nmi_clr,
	output logic nmi,
	output logic panel_en
);
	pcib_pkg::pcib_state_e st, next_st;
	logic [31:0] addr, dat;
	logic [3:0] cmd;
	logic [7:0] cnt;
	logic [2:0] ch;
	logic mode_ext, dma, mst, dir_to_mem, idsel_q;
	logic chk_v, chk_a, chk_p, perr_q, nmi_flag, par_q, par_oe_q;

	function automatic logic pcib_par(input logic [31:0] ad, input logic [3:0] be);
		return ^{ad, be};
	endfunction : pcib_par

	// Fixed priority, controller one reaches the bus through the cascade input
	function automatic logic [3:0] pcib_pick(input logic [7:0] r);
		logic [3:0] p;
		p = '0;
		for (int i = pcib_pkg::NCH - 1; i >= 0; i--) begin
			if (r[i] && i != pcib_pkg::CASC_CH) begin
				p = {1'b1, 3'(i)};
			end
		end
		return p;
	endfunction : pcib_pick

	wire is_io = cmd == pcib_pkg::CMD_IO_RD || cmd == pcib_pkg::CMD_IO_WR;
	wire is_mem = cmd == pcib_pkg::CMD_MEM_RD || cmd == pcib_pkg::CMD_MEM_WR;
	wire is_cfg = cmd == pcib_pkg::CMD_CFG_RD || cmd == pcib_pkg::CMD_CFG_WR;
	wire is_wr = cmd[pcib_pkg::CMD_WR_BIT];
	wire mem_hit = is_mem && ((addr & dec.mem_mask) == dec.mem_base);
	wire io_win = ((addr & dec.io_mask) == dec.io_base);
	wire io_hit = is_io && (io_win || addr < pcib_pkg::AT_IO_TOP);
	wire cfg_hit = is_cfg && idsel_q && addr[1:0] == pcib_pkg::CFG_TYPE0;
	wire pos_hit = mem_hit || io_hit || cfg_hit;
	wire sub_ok = (is_io && !sub_ign_io) || (is_mem && !sub_ign_mem);
	wire dec_end = cnt == 8'(SUB_CYC);
	wire sub_claim = st == pcib_pkg::S_DEC && !pos_hit && dec_end && pci_i.devsel_b && sub_ok;
	wire claim = st == pcib_pkg::S_DEC && (pos_hit || sub_claim);
	wire [3:0] pick = pcib_pick(dma_dreq);
	wire isa_wr = dma ? !dir_to_mem : is_wr;
	wire bus_idle = pci_i.frame_b && pci_i.irdy_b;
	wire mst_mem = !(isa_i.memr_b && isa_i.memw_b);
	wire ini_ph = st inside {pcib_pkg::S_DREQ, pcib_pkg::S_MADR, pcib_pkg::S_MDAT,
		pcib_pkg::S_MTURN};
	wire tgt_ph = !dma && st inside {pcib_pkg::S_ALE, pcib_pkg::S_CMD, pcib_pkg::S_RESP};
	wire isa_ph = !dma && st inside {pcib_pkg::S_ALE, pcib_pkg::S_CMD};
	wire cmd_ph = st == pcib_pkg::S_CMD;
	wire ale_ph = st == pcib_pkg::S_ALE && !mode_ext;
	wire [3:0] cbe_now = pci_oe.cbe ? pci_o.cbe : pci_i.cbe;
	wire par_err = chk_v && (pci_i.par != chk_p);

	always_comb begin
		next_st = st;
		case (st)
			pcib_pkg::S_IDLE: begin
				if (!pci_i.frame_b && pci_i.irdy_b) begin
					next_st = pcib_pkg::S_DEC;
				end else if (pick[3]) begin
					if (dma_cascade[pick[2:0]]) begin
						next_st = pcib_pkg::S_CASC;
					end else begin
						next_st = dma_to_mem ? pcib_pkg::S_CMD : pcib_pkg::S_DREQ;
					end
				end
			end
			pcib_pkg::S_DEC: begin
				if (claim) begin
					next_st = is_cfg ? pcib_pkg::S_RESP : pcib_pkg::S_ALE;
				end else if (!pci_i.devsel_b || dec_end) begin
					next_st = pcib_pkg::S_WAIT;
				end
			end
			pcib_pkg::S_WAIT: if (bus_idle) next_st = pcib_pkg::S_IDLE;
			pcib_pkg::S_ALE: begin
				if (cnt >= pcib_pkg::ALE_CYC - 8'h01 && (!is_wr || !pci_i.irdy_b)) begin
					next_st = pcib_pkg::S_CMD;
				end
			end
			pcib_pkg::S_CMD: begin
				if (cnt >= pcib_pkg::CMD_CYC && isa_i.iochrdy) begin
					if (!dma) next_st = pcib_pkg::S_RESP;
					else next_st = dir_to_mem ? pcib_pkg::S_DREQ : pcib_pkg::S_IDLE;
				end
			end
			pcib_pkg::S_RESP: if (!pci_i.irdy_b) next_st = pcib_pkg::S_TURN;
			pcib_pkg::S_TURN: next_st = pcib_pkg::S_IDLE;
			pcib_pkg::S_DREQ: begin
				if (!pci_i.gnt_b && bus_idle) next_st = pcib_pkg::S_MADR;
			end
			pcib_pkg::S_MADR: next_st = pcib_pkg::S_MDAT;
			pcib_pkg::S_MDAT: begin
				if (!pci_i.trdy_b || (pci_i.devsel_b && cnt >= pcib_pkg::MABORT_CYC)) begin
					next_st = pcib_pkg::S_MTURN;
				end
			end
			pcib_pkg::S_MTURN: begin
				if (mst) next_st = pcib_pkg::S_MHOLD;
				else next_st = dir_to_mem ? pcib_pkg::S_IDLE : pcib_pkg::S_CMD;
			end
			pcib_pkg::S_CASC: begin
				if (!dma_dreq[ch]) next_st = pcib_pkg::S_IDLE;
				else if (mode_ext && mst_mem) next_st = pcib_pkg::S_DREQ;
			end
			pcib_pkg::S_MHOLD: if (!mst_mem) next_st = pcib_pkg::S_CASC;
			default: next_st = pcib_pkg::S_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st <= pcib_pkg::S_IDLE;
			cnt <= '0;
			mode_ext <= 1'b0;
		end else begin
			st <= next_st;
			cnt <= (next_st != st) ? '0 : (cnt == pcib_pkg::CNT_MAX ? cnt : cnt + 8'h01);
			if (st == pcib_pkg::S_IDLE) mode_ext <= ext_master_sel;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			addr <= '0;
			cmd <= '0;
			idsel_q <= 1'b0;
			dma <= 1'b0;
			mst <= 1'b0;
			dir_to_mem <= 1'b0;
			ch <= '0;
		end else if (st == pcib_pkg::S_IDLE) begin
			dma <= 1'b0;
			mst <= 1'b0;
			if (next_st == pcib_pkg::S_DEC) begin
				addr <= pci_i.ad;
				cmd <= pci_i.cbe;
				idsel_q <= pci_i.idsel;
			end else if (pick[3]) begin
				ch <= pick[2:0];
				dma <= !dma_cascade[pick[2:0]];
				dir_to_mem <= dma_to_mem;
				addr <= {dma_page_hi, dma_addr};
				cmd <= dma_to_mem ? pcib_pkg::CMD_MEM_WR : pcib_pkg::CMD_MEM_RD;
			end
		end else if (st == pcib_pkg::S_CASC && next_st == pcib_pkg::S_DREQ) begin
			mst <= 1'b1;
			addr <= 32'(isa_i.sa);
			cmd <= isa_i.memw_b ? pcib_pkg::CMD_MEM_RD : pcib_pkg::CMD_MEM_WR;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dat <= '0;
		end else if (claim && is_cfg) begin
			dat <= (addr[7:2] == pcib_pkg::CFG_REG_ID) ? CFG_ID : '0;
		end else if (st == pcib_pkg::S_ALE && is_wr && !pci_i.irdy_b) begin
			dat <= pci_i.ad;
		end else if (cmd_ph && next_st != st && !isa_wr) begin
			dat <= 32'(isa_i.sd);
		end else if (st == pcib_pkg::S_MDAT && !pci_i.trdy_b && !is_wr) begin
			dat <= pci_i.ad;
		end else if (st == pcib_pkg::S_CASC && next_st == pcib_pkg::S_DREQ) begin
			dat <= 32'(isa_i.sd);
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			chk_v <= 1'b0;
			chk_a <= 1'b0;
			chk_p <= 1'b0;
			perr_q <= 1'b0;
			par_q <= 1'b0;
			par_oe_q <= 1'b0;
			nmi_flag <= 1'b0;
		end else begin
			chk_v <= (st == pcib_pkg::S_IDLE && next_st == pcib_pkg::S_DEC)
				|| (st == pcib_pkg::S_RESP && is_wr && !pci_i.irdy_b)
				|| (st == pcib_pkg::S_MDAT && !is_wr && !pci_i.trdy_b);
			chk_a <= st == pcib_pkg::S_IDLE;
			chk_p <= pcib_par(pci_i.ad, pci_i.cbe);
			perr_q <= par_err && !chk_a;
			par_q <= pcib_par(pci_o.ad, cbe_now);
			par_oe_q <= pci_oe.ad;
			if (nmi_en && (par_err || !pci_i.serr_b)) nmi_flag <= 1'b1;
			else if (nmi_clr) nmi_flag <= 1'b0;
		end
	end

	// Request is held through the whole transfer so ownership is not lost
	assign pci_o.req_b = !ini_ph;
	assign pci_o.frame_b = st != pcib_pkg::S_MADR;
	assign pci_o.irdy_b = st != pcib_pkg::S_MDAT;
	assign pci_o.trdy_b = st != pcib_pkg::S_RESP;
	assign pci_o.devsel_b = !tgt_ph;
	assign pci_o.cbe = (st == pcib_pkg::S_MADR) ? cmd : pcib_pkg::BE_ALL;
	assign pci_o.ad = (st == pcib_pkg::S_MADR) ? addr : dat;
	assign pci_o.par = par_q;
	assign pci_o.perr_b = !perr_q;
	assign pci_oe.frame = st inside {pcib_pkg::S_MADR, pcib_pkg::S_MDAT, pcib_pkg::S_MTURN};
	assign pci_oe.irdy = pci_oe.frame;
	assign pci_oe.cbe = st inside {pcib_pkg::S_MADR, pcib_pkg::S_MDAT};
	assign pci_oe.devsel = tgt_ph || st == pcib_pkg::S_TURN;
	assign pci_oe.trdy = pci_oe.devsel;
	assign pci_oe.ad = st == pcib_pkg::S_MADR || (st == pcib_pkg::S_MDAT && is_wr)
		|| (st == pcib_pkg::S_RESP && !is_wr);
	assign pci_oe.par = par_oe_q;
	assign pci_oe.perr = perr_q;

	// Shared bus carries the address for the external latch, then data
	assign isa_o.address_latch_strobe = ale_ph;
	assign isa_o.sd = ale_ph ? addr[15:0] : dat[15:0];
	assign isa_o.sd_oe = ale_ph || (cmd_ph && isa_wr)
		|| (st == pcib_pkg::S_MHOLD && !isa_i.memr_b);
	assign isa_o.sa = addr[23:0];
	assign isa_o.sa_oe = mode_ext && isa_ph;
	assign isa_o.gpio_hi = addr[23:20];
	assign isa_o.gpio_hi_oe = !mode_ext && isa_ph;
	assign isa_o.ior_b = !(cmd_ph && (dma ? dir_to_mem : (is_io && !is_wr)));
	assign isa_o.iow_b = !(cmd_ph && (dma ? !dir_to_mem : (is_io && is_wr)));
	assign isa_o.memr_b = !(cmd_ph && !dma && is_mem && !is_wr);
	assign isa_o.memw_b = !(cmd_ph && !dma && is_mem && is_wr);
	assign isa_o.cmd_oe = !(st == pcib_pkg::S_CASC || mst);
	assign isa_o.iochrdy_oe = mst && ini_ph;
	assign dma_dack_b = ~(((dma && cmd_ph) || st == pcib_pkg::S_CASC || mst)
		? (pcib_pkg::ONE_CH << ch) : '0);
	assign panel_en = !mode_ext;
	assign nmi = nmi_flag;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	property p_ale;
		isa_o.address_latch_strobe |-> !mode_ext && isa_o.sd == addr[15:0] && isa_o.sd_oe;
	endproperty
	a_ale: assert property (p_ale) else $error("latch strobe without address");
	property p_gpio_hi;
		isa_o.gpio_hi_oe |-> !mode_ext && isa_o.gpio_hi == addr[23:20];
	endproperty
	a_gpio_hi: assert property (p_gpio_hi) else $error("upper address pins wrong");
	property p_panel;
		mode_ext |-> !panel_en && !isa_o.gpio_hi_oe;
	endproperty
	a_panel: assert property (p_panel) else $error("panel enabled in master mode");
	property p_sub;
		sub_claim |-> cnt == 8'(SUB_CYC) && pci_i.devsel_b ##1 !pci_o.devsel_b;
	endproperty
	a_sub: assert property (p_sub) else $error("early subtractive claim");
	property p_ign;
		st == pcib_pkg::S_DEC && !pos_hit && !sub_ok |=> st != pcib_pkg::S_ALE;
	endproperty
	a_ign: assert property (p_ign) else $error("ignored cycle forwarded");
	property p_par;
		pci_oe.ad |=> pci_oe.par && pci_o.par == ^{$past(pci_o.ad), $past(cbe_now)};
	endproperty
	a_par: assert property (p_par) else $error("bad generated parity");
	property p_rdy;
		cmd_ph && !isa_i.iochrdy |=> cmd_ph;
	endproperty
	a_rdy: assert property (p_rdy) else $error("cycle ended while not ready");
	property p_gnt;
		st == pcib_pkg::S_MADR |-> $past(!pci_i.gnt_b) && !pci_o.req_b;
	endproperty
	a_gnt: assert property (p_gnt) else $error("initiator without grant");
	property p_mst_io;
		st == pcib_pkg::S_CASC && !mst_mem |=> st != pcib_pkg::S_DREQ;
	endproperty
	a_mst_io: assert property (p_mst_io) else $error("master I/O passed to PCI");
	property p_nmi;
		nmi_en && !pci_i.serr_b |=> nmi ##1 (nmi || $past(nmi_clr));
	endproperty
	a_nmi: assert property (p_nmi) else $error("no NMI on system error");
	property p_dack;
		dma_dack_b[pcib_pkg::CASC_CH] && $onehot0(~dma_dack_b);
	endproperty
	a_dack: assert property (p_dack) else $error("bad DMA acknowledge");
	c_sub: cover property (sub_claim ##[1:40] st == pcib_pkg::S_TURN);
	c_dma: cover property (dma && st == pcib_pkg::S_MTURN);
	c_mst: cover property (mst && st == pcib_pkg::S_MHOLD);
	c_cfg: cover property (claim && is_cfg);
endmodule : pcib_bridge
`default_nettype wire

// ---- rtl/pcib_pkg.sv ----
package pcib_pkg;
	localparam logic [3:0] CMD_IO_RD = 4'h2;
	localparam logic [3:0] CMD_IO_WR = 4'h3;
	localparam logic [3:0] CMD_MEM_RD = 4'h6;
	localparam logic [3:0] CMD_MEM_WR = 4'h7;
	localparam logic [3:0] CMD_CFG_RD = 4'ha;
	localparam logic [3:0] CMD_CFG_WR = 4'hb;
	localparam logic [3:0] BE_ALL = 4'h0;
	localparam int CMD_WR_BIT = 0;
	localparam logic [1:0] CFG_TYPE0 = 2'h0;
	localparam logic [5:0] CFG_REG_ID = 6'h00;
	localparam logic [31:0] AT_IO_TOP = 32'h0000_0100;
	localparam int NCH = 8;
	localparam int CASC_CH = 4;
	localparam logic [7:0] ONE_CH = 8'h01;
	localparam int CLK_NS = 40;
	localparam int ALE_NS = 80;
	localparam int CMD_NS = 500;
	localparam logic [7:0] ALE_CYC = 8'((ALE_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] CMD_CYC = 8'((CMD_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] MABORT_CYC = 8'h05;
	localparam logic [7:0] CNT_MAX = 8'hff;
	localparam int SUB_WAIT_CYC = 3;

	typedef enum logic [3:0] {
		S_IDLE, S_DEC, S_WAIT, S_ALE, S_CMD, S_RESP, S_TURN,
		S_DREQ, S_MADR, S_MDAT, S_MTURN, S_CASC, S_MHOLD
	} pcib_state_e;

	typedef struct packed {
		logic frame_b; logic irdy_b; logic trdy_b; logic devsel_b;
		logic idsel; logic gnt_b; logic serr_b; logic par;
		logic [3:0] cbe; logic [31:0] ad;
	} pcib_pci_in_s;

	typedef struct packed {
		logic frame_b; logic irdy_b; logic trdy_b; logic devsel_b;
		logic req_b; logic par; logic perr_b;
		logic [3:0] cbe; logic [31:0] ad;
	} pcib_pci_out_s;

	typedef struct packed {
		logic frame; logic irdy; logic trdy; logic devsel;
		logic par; logic perr; logic cbe; logic ad;
	} pcib_pci_oe_s;

	typedef struct packed {
		logic [31:0] mem_base; logic [31:0] mem_mask;
		logic [31:0] io_base; logic [31:0] io_mask;
	} pcib_dec_s;

	typedef struct packed {
		logic iochrdy; logic memr_b; logic memw_b;
		logic [15:0] sd; logic [23:0] sa;
	} pcib_isa_in_s;

	typedef struct packed {
		logic address_latch_strobe; logic ior_b; logic iow_b;
		logic memr_b; logic memw_b; logic cmd_oe; logic iochrdy_oe;
		logic sd_oe; logic sa_oe; logic gpio_hi_oe;
		logic [15:0] sd; logic [23:0] sa; logic [3:0] gpio_hi;
	} pcib_isa_out_s;
endpackage : pcib_pkg

// ---- verif/pci_to_isa_cycle_bridge_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module pci_to_isa_cycle_bridge_tb_top;
	localparam logic [31:0] ID = 32'h55aa_0f0f; // Arbitrary identity value
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	pcib_pkg::pcib_pci_in_s pin;
	pcib_pkg::pcib_pci_out_s pci_o;
	pcib_pkg::pcib_pci_oe_s pci_oe;
	pcib_pkg::pcib_dec_s dec = '{32'h000d_0000, 32'hffff_0000, 32'h0000_0300, 32'hffff_ff00};
	pcib_pkg::pcib_isa_in_s isa_i;
	pcib_pkg::pcib_isa_out_s isa_o;
	logic hfr_b = 1'b1, hirdy_b = 1'b1, hdrv = 1'b0, hidsel = 1'b0, hserr_b = 1'b1, inj = 1'b0;
	logic hpar = 1'b0, ext = 1'b0, to_mem = 1'b0, nmi_en = 1'b0, nmi_clr = 1'b0, hmr_b = 1'b1;
	logic sub_ign_io = 1'b0, sub_ign_mem = 1'b0, seen_perr = 1'b0, iochrdy, gnt_b, tgt_b;
	logic [31:0] had = 32'h0000_0000, a, rnd;
	logic [3:0] hcbe = 4'h0, stretch = 4'h0;
	logic [7:0] dreq = 8'h00, casc = 8'h00, dack_b;
	logic [23:0] hsa = 24'h00_0000;
	logic [15:0] msd;
	logic nmi, panel_en;
	logic [31:0] qd[$], qa[$];
	int err_total = 0, comparisons = 0, cyc = 0, n;
	always #20 clk = ~clk;
	always_comb begin
		pin.frame_b = pci_oe.frame ? pci_o.frame_b : hfr_b;
		pin.irdy_b = pci_oe.irdy ? pci_o.irdy_b : hirdy_b;
		pin.trdy_b = (pci_oe.trdy ? pci_o.trdy_b : 1'b1) & tgt_b;
		pin.devsel_b = (pci_oe.devsel ? pci_o.devsel_b : 1'b1) & tgt_b;
		pin.idsel = hidsel;
		pin.gnt_b = gnt_b;
		pin.serr_b = hserr_b;
		pin.par = pci_oe.par ? pci_o.par : hpar;
		pin.cbe = pci_oe.cbe ? pci_o.cbe : hcbe;
		pin.ad = pci_oe.ad ? pci_o.ad : (hdrv ? had : ~had);
		isa_i = '{iochrdy, hmr_b, 1'b1, msd, isa_o.sa_oe ? isa_o.sa : hsa};
	end
	pcib_bridge #(.SUB_CYC(pcib_pkg::SUB_WAIT_CYC), .CFG_ID(ID)) u_pcib_bridge (
		.clk(clk), .rst_b(rst_b), .pci_i(pin), .pci_o(pci_o), .pci_oe(pci_oe), .dec(dec),
		.sub_ign_io(sub_ign_io), .sub_ign_mem(sub_ign_mem), .ext_master_sel(ext),
		.isa_i(isa_i), .isa_o(isa_o), .dma_dreq(dreq), .dma_cascade(casc), .dma_to_mem(to_mem),
		.dma_addr(rnd[23:0]), .dma_page_hi(rnd[31:24]), .dma_dack_b(dack_b), .nmi_en(nmi_en),
		.nmi_clr(nmi_clr), .nmi(nmi), .panel_en(panel_en));
	pcib_far_model u_pcib_far_model (.clk(clk), .rst_b(rst_b), .isa_o(isa_o), .pci_o(pci_o),
		.pci_oe(pci_oe), .stretch(stretch), .iochrdy(iochrdy), .sd(msd), .gnt_b(gnt_b),
		.tgt_b(tgt_b));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk32
	task automatic chk1(input string nm, input logic e, input logic g);
		chk32(nm, {31'h0, e}, {31'h0, g});
	endtask : chk1
	task automatic results;
		if (err_total == 0 && comparisons > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : results
	task automatic wait_dack(input logic [7:0] v);
		n = 0;
		while (n < 400 && dack_b !== v) begin
			@(negedge clk);
			n++;
		end
		chk32("dack_b", {24'h0, v}, {24'h0, dack_b});
	endtask : wait_dack
	task automatic pci_tx(input logic [3:0] cmd, input logic [31:0] ad, input logic [31:0] wd,
		input logic sel, input logic claim, input logic pos, input logic bad, input logic [31:0] rx);
		int seen;
		seen = 0;
		n = 0;
		if (claim && !cmd[0]) qd.push_back(rx);
		@(negedge clk);
		hfr_b = 1'b0;
		had = ad;
		hcbe = cmd;
		hidsel = sel;
		hdrv = 1'b1;
		@(negedge clk);
		hfr_b = 1'b1;
		hirdy_b = 1'b0;
		hcbe = pcib_pkg::BE_ALL;
		had = wd;
		hdrv = cmd[pcib_pkg::CMD_WR_BIT];
		hidsel = 1'b0;
		inj = bad;
		while (n < 60 && pin.trdy_b !== 1'b0) begin
			@(negedge clk);
			n++;
			if (seen == 0 && pin.devsel_b === 1'b0) seen = n;
		end
		@(negedge clk);
		hirdy_b = 1'b1;
		hdrv = 1'b0;
		inj = 1'b0;
		chk1("claimed", claim, seen != 0);
		if (claim) chk1("claim_time", 1'b1, pos ? seen <= 3 : seen > pcib_pkg::SUB_WAIT_CYC);
		repeat (3) @(negedge clk);
	endtask : pci_tx
	always @(posedge clk) begin
		hpar <= ^{pin.ad, pin.cbe} ^ (inj && !pin.irdy_b);
		cyc <= cyc + 1;
		if (pci_oe.par && pci_oe.ad === 1'b0) chk1("par", hpar, pci_o.par);
		if (pci_oe.ad && pci_oe.trdy && !pin.trdy_b && !pin.irdy_b)
			chk32("rdata", qd.size() ? qd.pop_front() : 32'hxxxx_xxxx, pin.ad);
		if (pci_oe.frame && !pci_o.frame_b && pci_oe.ad && pin.irdy_b)
			chk32("init_addr", qa.size() ? qa.pop_front() : 32'hxxxx_xxxx, pin.ad);
		if (pci_oe.perr && !pci_o.perr_b) seen_perr <= 1'b1;
		if (cyc == 8000) begin
			err_total++;
			results();
		end
	end
	initial begin
		rnd = 32'hd143_e1f4;
		repeat (5) @(negedge clk);
		rst_b = 1'b1;
		chk1("panel_en", 1'b1, panel_en);
		chk32("dack_b", 32'h0000_00ff, {24'h0, dack_b});
		rnd = lfsr(rnd);
		a = 32'h0000_0300 | {24'h0, rnd[7:0]};
		pci_tx(pcib_pkg::CMD_IO_RD, a, 0, 0, 1, 1, 0, {16'h0, a[15:0] ^ 16'h5a5a});
		chk32("latched", {16'h0, a[15:0]}, {16'h0, u_pcib_far_model.lat});
		for (int s = 0; s < 4; s++) begin
			{sub_ign_io, sub_ign_mem} = 2'(s);
			rnd = lfsr(rnd);
			stretch = rnd[3:0];
			a = {8'h00, 4'ha, rnd[19:0]};
			pci_tx(pcib_pkg::CMD_MEM_RD, a, 0, 0, !sub_ign_mem, 0, 0, {16'h0, a[15:0] ^ 16'h5a5a});
			if (!sub_ign_mem) chk32("upper", 32'ha, {28'h0, u_pcib_far_model.lat_hi});
			a = {16'h0, 4'h2, rnd[31:20]};
			pci_tx(pcib_pkg::CMD_IO_WR, a, rnd, 0, !sub_ign_io, 0, 0, 0);
			if (!sub_ign_io) chk32("latched", {16'h0, a[15:0]}, {16'h0, u_pcib_far_model.lat});
		end
		a = {24'h0, rnd[7:0]};
		pci_tx(pcib_pkg::CMD_IO_RD, a, 0, 0, 1, 1, 0, {16'h0, a[15:0] ^ 16'h5a5a});
		pci_tx(pcib_pkg::CMD_CFG_WR, 32'h0, rnd, 1, 1, 1, 0, 0);
		pci_tx(pcib_pkg::CMD_CFG_RD, 32'h0, 0, 1, 1, 1, 0, ID);
		pci_tx(pcib_pkg::CMD_CFG_RD, 32'h0, 0, 0, 0, 1, 0, 0);
		nmi_en = 1'b1;
		pci_tx(pcib_pkg::CMD_MEM_WR, 32'h000d_0000 | rnd[15:0], rnd, 0, 1, 1, 1, 0);
		chk1("perr", 1'b1, seen_perr);
		chk1("nmi", 1'b1, nmi);
		for (int e = 0; e < 2; e++) begin
			nmi_clr = 1'b1;
			@(negedge clk);
			nmi_clr = 1'b0;
			nmi_en = e[0];
			hserr_b = 1'b0;
			@(negedge clk);
			hserr_b = 1'b1;
			repeat (3) @(negedge clk);
			chk1("nmi", e[0], nmi);
		end
		for (int k = 0; k < 2; k++) begin
			rnd = lfsr(rnd);
			to_mem = k[0];
			qa.push_back(rnd);
			dreq = k ? 8'h50 : 8'h16;
			wait_dack(k ? 8'hbf : 8'hfd);
			dreq = 8'h00;
			wait_dack(8'hff);
			repeat (12) @(negedge clk);
			chk32("pending", 32'h0, qa.size());
		end
		ext = 1'b1;
		repeat (2) @(negedge clk);
		chk1("panel_en", 1'b0, panel_en);
		casc = 8'h20;
		dreq = 8'h20;
		wait_dack(8'hdf);
		hsa = rnd[23:0];
		qa.push_back({8'h00, rnd[23:0]});
		hmr_b = 1'b0;
		repeat (3) @(negedge clk);
		n = 0;
		while (n < 200 && iochrdy !== 1'b1) begin
			@(negedge clk);
			n++;
		end
		hmr_b = 1'b1;
		chk32("pending", 32'h0, qa.size());
		dreq = 8'h00;
		wait_dack(8'hff);
		ext = 1'b0;
		repeat (3) @(negedge clk);
		chk1("panel_en", 1'b1, panel_en);
		results();
	end
endmodule : pci_to_isa_cycle_bridge_tb_top
`default_nettype wire

// ---- verif/pcib_far_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module pcib_far_model (
	input wire logic clk,
	input wire logic rst_b,
	input wire pcib_pkg::pcib_isa_out_s isa_o,
	input wire pcib_pkg::pcib_pci_out_s pci_o,
	input wire pcib_pkg::pcib_pci_oe_s pci_oe,
	input wire logic [3:0] stretch,
	output logic iochrdy,
	output logic [15:0] sd,
	output logic gnt_b,
	output logic tgt_b
);
	logic [15:0] lat;
	logic [3:0] lat_hi;
	logic [3:0] wcnt;
	logic cmd_d;
	wire cmd = isa_o.cmd_oe && !(isa_o.ior_b && isa_o.iow_b && isa_o.memr_b && isa_o.memw_b);
	wire rd = isa_o.cmd_oe && !(isa_o.ior_b && isa_o.memr_b);
	// Read data from the latched address; inverted while nobody drives
	assign sd = isa_o.sd_oe ? isa_o.sd : (rd ? lat ^ 16'h5a5a : ~(lat ^ 16'h5a5a));
	assign iochrdy = !isa_o.iochrdy_oe && wcnt == 4'h0;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			lat <= 16'h0000;
			lat_hi <= 4'h0;
			wcnt <= 4'h0;
			cmd_d <= 1'b0;
			gnt_b <= 1'b1;
			tgt_b <= 1'b1;
		end else begin
			if (isa_o.address_latch_strobe) begin
				lat <= isa_o.sd;
				lat_hi <= isa_o.gpio_hi;
			end
			cmd_d <= cmd;
			wcnt <= (cmd && !cmd_d) ? stretch : wcnt - {3'h0, wcnt != 4'h0};
			gnt_b <= pci_o.req_b;
			if (!tgt_b && pci_oe.irdy && !pci_o.irdy_b) begin
				tgt_b <= 1'b1;
			end else if (pci_oe.frame && !pci_o.frame_b) begin
				tgt_b <= 1'b0;
			end
		end
	end
endmodule : pcib_far_model
`default_nettype wire
